/* rtl/fofc_flag_offset_ctrl.sv */
// Flag offset control of a 65,536 x 36 FIFO: offset registers, word count and status flags.
// Write and read clocks arrive as pins and are sampled on ref_clk, which must run well above both.
// The memory array itself sits outside; this block issues its strobes and passes its data.
//
// How it works
// - load select low at master reset picks default 16383, 8191, 4095 or 127.
// - load select high at master reset picks default 2047, 1023, 511 or 255.
// - load select at master reset fixes serial or parallel loading until next reset.
// - offsets read back only over the parallel output bus, never serially.
// - offsets may be reprogrammed anytime; host keeps them within 0 to depth-1.
// - synchronous mode updates almost-full only on write clock edges.
// - synchronous mode updates almost-empty only on read clock edges.
// - asynchronous almost-full falls on write edge, rises on read edge.
// - asynchronous almost-empty falls on read edge, rises on write edge.
// - standard mode flag thresholds against word count and offsets.
// - fall-through thresholds count the output register, one word more.
// - parallel write loads offset bytes in order on write clock edges.
// - parallel read presents offset bytes in order on read clock edges.
// - serial shift loads 32 bits, empty offset LSB first, full MSB last.
// - same offset sequence in standard and fall-through modes.
// - timing select pin high at master reset selects fall-through mode.
// - writes ignored when full, reads ignored when empty.
// - master reset returns both offset pointers to empty offset low.
// - serial loading marks programmable flags invalid until all bits shifted.
//
`timescale 1ns/1ns
`default_nettype none

`include "fofc_defs.svh"

module fofc_flag_offset_ctrl
  import fofc_pkg::*;
(
  input  wire logic                      ref_clk,
  input  wire logic                      rst,
  input  wire logic                      clkEnable,
  input  wire logic                      writeClkPin,
  input  wire logic                      readClkPin,
  input  wire logic                      writeEnablePin_n,
  input  wire logic                      readEnablePin_n,
  input  wire logic                      offsetLoadSelect,
  input  wire logic                      serialShiftEnable,
  input  wire logic                      defaultOffsetPick0,
  input  wire logic                      defaultOffsetPick1,
  input  wire logic                      flagTimingSelect,
  input  wire logic                      timingSelectSerialIn,
  input  wire logic                      masterReset_n,
  input  wire logic [`FOFC_DATA_W-1:0]   dataInputBus,
  input  wire logic [`FOFC_DATA_W-1:0]   memReadData,
  output logic      [`FOFC_DATA_W-1:0]   dataOutputBus,
  output logic      [`FOFC_DATA_W-1:0]   memWriteData,
  output logic                           memWriteStrobe,
  output logic                           memReadStrobe,
  output logic                           emptyFlag,
  output logic                           fullFlag,
  output logic                           halfFullFlag,
  output logic                           almostEmptyFlag,
  output logic                           almostFullFlag,
  output logic                           offsetsValid,
  output logic                           firstWordFallThrough,
  output logic                           serialLoadMode
);

  logic [`FOFC_PIN_W-1:0]     pinRaw;
  logic [`FOFC_PIN_W-1:0]     pinSync;
  logic                       wclkS;
  logic                       rclkS;
  logic                       wenS_n;
  logic                       renS_n;
  logic                       ldS;
  logic                       senS;
  logic [1:0]                 pickS;
  logic                       pfmS;
  logic                       siS;
  logic                       mrsS_n;
  logic [`FOFC_DATA_W-1:0]    dinS;

  logic                       wclkPrev_q;
  logic                       rclkPrev_q;
  logic                       wEdge;
  logic                       rEdge;
  logic                       inReset;

  logic                       syncFlags_q;
  logic [2*`FOFC_OFS_W-1:0]   offsetBits_q;
  logic [1:0]                 wrPtr_q;
  logic [1:0]                 rdPtr_q;
  logic [4:0]                 serCount_q;
  logic [`FOFC_CNT_W-1:0]     count_q;
  logic [`FOFC_CNT_W-1:0]     countD;

  fofc_wop_t                  wop;
  fofc_rop_t                  rop;
  logic                       wrAccept;
  logic                       rdAccept;
  logic [`FOFC_OFS_W-1:0]     emptyOfs;
  logic [`FOFC_OFS_W-1:0]     fullOfs;
  logic [`FOFC_CNT_W-1:0]     capacity;
  logic [`FOFC_CNT_W-1:0]     extra;
  logic                       aeLowD;
  logic                       afLowD;
  logic                       hfLowD;
  logic [`FOFC_OFS_W-1:0]     defaultNow;

  assign pinRaw = {dataInputBus, masterReset_n, timingSelectSerialIn, flagTimingSelect,
                   defaultOffsetPick1, defaultOffsetPick0, serialShiftEnable, offsetLoadSelect,
                   readEnablePin_n, writeEnablePin_n, readClkPin, writeClkPin};

  fofc_pin_sync #(
    .WIDTH (`FOFC_PIN_W)
  ) u_pin_sync (
    .clk       (ref_clk),
    .rst       (rst),
    .clkEnable (clkEnable),
    .pinIn     (pinRaw),
    .pinOut    (pinSync)
  );

  assign wclkS  = pinSync[0];
  assign rclkS  = pinSync[1];
  assign wenS_n = pinSync[2];
  assign renS_n = pinSync[3];
  assign ldS    = pinSync[4];
  assign senS   = pinSync[5];
  assign pickS  = pinSync[7:6];
  assign pfmS   = pinSync[8];
  assign siS    = pinSync[9];
  assign mrsS_n = pinSync[10];
  assign dinS   = pinSync[`FOFC_PIN_W-1:`FOFC_PIN_CTRL_W];

  assign inReset = ~mrsS_n;

  // Rising edges of the sampled write and read clocks.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wclkPrev_q <= 1'b0;
      rclkPrev_q <= 1'b0;
    end else if (clkEnable) begin
      wclkPrev_q <= wclkS;
      rclkPrev_q <= rclkS;
    end
  end

  assign wEdge = wclkS & ~wclkPrev_q & ~inReset;
  assign rEdge = rclkS & ~rclkPrev_q & ~inReset;

  // Default offset for the current load select and pick pins.
  always_comb begin
    case ({ldS, pickS})
      3'b0_10: defaultNow = `FOFC_DEF_16383;
      3'b0_01: defaultNow = `FOFC_DEF_8191;
      3'b0_11: defaultNow = `FOFC_DEF_4095;
      3'b0_00: defaultNow = `FOFC_DEF_127;
      3'b1_10: defaultNow = `FOFC_DEF_2047;
      3'b1_00: defaultNow = `FOFC_DEF_1023;
      3'b1_01: defaultNow = `FOFC_DEF_511;
      3'b1_11: defaultNow = `FOFC_DEF_255;
      default: defaultNow = `FOFC_DEF_127;
    endcase
  end

  // Configuration straps are caught on every cycle that master reset is held.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      serialLoadMode       <= 1'b0;
      firstWordFallThrough <= 1'b0;
      syncFlags_q          <= 1'b0;
    end else if (clkEnable && inReset) begin
      serialLoadMode       <= ldS;
      firstWordFallThrough <= siS;
      syncFlags_q          <= pfmS;
    end
  end

  // Operation decode from the control pins.
  always_comb begin
    wop = FOFC_WOP_NONE;
    rop = FOFC_ROP_NONE;
    if (ldS) begin
      if (!wenS_n) begin
        wop = FOFC_WOP_MEM;
      end
      if (!renS_n) begin
        rop = FOFC_ROP_MEM;
      end
    end else begin
      if (!wenS_n && renS_n && senS && !serialLoadMode) begin
        wop = FOFC_WOP_OFS;
      end
      if (wenS_n && renS_n && !senS && serialLoadMode) begin
        wop = FOFC_WOP_SHIFT;
      end
      if (wenS_n && !renS_n && senS) begin
        rop = FOFC_ROP_OFS;
      end
    end
  end

  assign emptyOfs = offsetBits_q[`FOFC_OFS_W-1:0];
  assign fullOfs  = offsetBits_q[2*`FOFC_OFS_W-1:`FOFC_OFS_W];
  assign extra    = {{(`FOFC_CNT_W-1){1'b0}}, firstWordFallThrough};
  assign capacity = `FOFC_DEPTH + extra;

  assign wrAccept = wEdge && (wop == FOFC_WOP_MEM) && (count_q != capacity);
  assign rdAccept = rEdge && (rop == FOFC_ROP_MEM) && (count_q != '0);

  assign countD = count_q + {{(`FOFC_CNT_W-1){1'b0}}, wrAccept}
                          - {{(`FOFC_CNT_W-1){1'b0}}, rdAccept};

  assign aeLowD = countD <= ({2'b00, emptyOfs} + extra);
  assign afLowD = countD >= (capacity - {2'b00, fullOfs});
  assign hfLowD = countD > (`FOFC_HALF + extra);

  // Offset storage, loaded by default, parallel byte writes or serial shifting.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      offsetBits_q <= {`FOFC_DEF_127, `FOFC_DEF_127};
    end else if (clkEnable) begin
      if (inReset) begin
        offsetBits_q <= {defaultNow, defaultNow};
      end else if (wEdge && wop == FOFC_WOP_OFS) begin
        // one sequence for both timing modes
        offsetBits_q[wrPtr_q*8 +: 8] <= dinS[7:0];
      end else if (wEdge && wop == FOFC_WOP_SHIFT) begin
        offsetBits_q <= {siS, offsetBits_q[2*`FOFC_OFS_W-1:1]};
      end
    end
  end

  // Independent offset write and read pointers.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wrPtr_q <= `FOFC_PTR_RST;
      rdPtr_q <= `FOFC_PTR_RST;
    end else if (clkEnable) begin
      if (inReset) begin
        wrPtr_q <= `FOFC_PTR_RST;
        rdPtr_q <= `FOFC_PTR_RST;
      end else begin
        if (wEdge && wop == FOFC_WOP_OFS) begin
          wrPtr_q <= wrPtr_q + 2'h1;
        end
        if (rEdge && rop == FOFC_ROP_OFS) begin
          rdPtr_q <= rdPtr_q + 2'h1;
        end
      end
    end
  end

  // Serial bit count and validity of the programmable flags.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      serCount_q   <= 5'h00;
      offsetsValid <= 1'b1;
    end else if (clkEnable) begin
      if (inReset) begin
        serCount_q   <= 5'h00;
        offsetsValid <= 1'b1;
      end else if (wEdge && wop == FOFC_WOP_SHIFT) begin
        // invalid until the set is complete
        serCount_q   <= (serCount_q == `FOFC_SER_LAST) ? 5'h00 : serCount_q + 5'h01;
        offsetsValid <= (serCount_q == `FOFC_SER_LAST);
      end
    end
  end

  // Word count of memory plus output register.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      count_q <= '0;
    end else if (clkEnable) begin
      count_q <= inReset ? '0 : countD;
    end
  end

  // Memory strobes and the output bus.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      memWriteStrobe <= 1'b0;
      memReadStrobe  <= 1'b0;
      memWriteData   <= '0;
      dataOutputBus  <= '0;
    end else if (clkEnable) begin
      memWriteStrobe <= wrAccept;
      memReadStrobe  <= rdAccept;
      if (wrAccept) begin
        memWriteData <= dinS;
      end
      if (inReset) begin
        dataOutputBus <= '0;
      end else if (rdAccept) begin
        dataOutputBus <= memReadData;
      end else if (rEdge && rop == FOFC_ROP_OFS) begin
        dataOutputBus <= {28'h000_0000, offsetBits_q[rdPtr_q*8 +: 8]};
      end
    end
  end

  // Empty, full and half-full flags; empty and full polarity differs by timing mode, half-full is active low in both.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      emptyFlag    <= 1'b0;
      fullFlag     <= 1'b1;
      halfFullFlag <= 1'b1;
    end else if (clkEnable) begin
      emptyFlag    <= firstWordFallThrough ? (countD == '0) : (countD != '0);
      fullFlag     <= firstWordFallThrough ? (countD == capacity) : (countD != capacity);
      halfFullFlag <= ~hfLowD;
    end
  end

  // Programmable flags, held while offsets are incomplete.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      almostEmptyFlag <= 1'b0;
      almostFullFlag  <= 1'b1;
    end else if (clkEnable) begin
      if (inReset) begin
        almostEmptyFlag <= 1'b0;
        almostFullFlag  <= 1'b1;
      end else if (offsetsValid) begin
        if (syncFlags_q) begin
          if (wEdge) begin
            almostFullFlag <= ~afLowD;
          end
          if (rEdge) begin
            almostEmptyFlag <= ~aeLowD;
          end
        end else begin
          if (wEdge && afLowD) begin
            almostFullFlag <= 1'b0;
          end else if (rEdge && !afLowD) begin
            almostFullFlag <= 1'b1;
          end
          if (rEdge && aeLowD) begin
            almostEmptyFlag <= 1'b0;
          end else if (wEdge && !aeLowD) begin
            almostEmptyFlag <= 1'b1;
          end
        end
      end
    end
  end

endmodule

`default_nettype wire

/* rtl/fofc_defs.svh */
// Constants of the FIFO flag and offset control block.
// Assumes one fixed depth of 65,536 words and a 36-bit data path.
`ifndef FOFC_DEFS_SVH
`define FOFC_DEFS_SVH

`define FOFC_DATA_W       36
`define FOFC_OFS_W        16
`define FOFC_CNT_W        18
`define FOFC_DEPTH        18'h1_0000
`define FOFC_HALF         18'h0_8000
`define FOFC_SER_BITS     32
`define FOFC_SER_LAST     5'h1F
`define FOFC_PIN_CTRL_W   11
`define FOFC_PIN_W        47

`define FOFC_DEF_16383    16'h3FFF
`define FOFC_DEF_8191     16'h1FFF
`define FOFC_DEF_4095     16'h0FFF
`define FOFC_DEF_127      16'h007F
`define FOFC_DEF_2047     16'h07FF
`define FOFC_DEF_1023     16'h03FF
`define FOFC_DEF_511      16'h01FF
`define FOFC_DEF_255      16'h00FF

`define FOFC_PTR_RST      2'h0

`endif

/* rtl/fofc_pkg.sv */
// Types shared by the FIFO flag and offset control block.
// Assumes the constants header is on the include path.
package fofc_pkg;

  typedef enum logic [1:0] {
    FOFC_WOP_NONE,
    FOFC_WOP_MEM,
    FOFC_WOP_OFS,
    FOFC_WOP_SHIFT
  } fofc_wop_t;

  typedef enum logic [1:0] {
    FOFC_ROP_NONE,
    FOFC_ROP_MEM,
    FOFC_ROP_OFS
  } fofc_rop_t;

endpackage

/* rtl/fofc_pin_sync.sv */
// Two-stage synchroniser for a group of pins.
// Assumes the pins are asynchronous to clk and that each bit is used on its own.
`timescale 1ns/1ns
`default_nettype none

module fofc_pin_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             clkEnable,
  input  wire logic [WIDTH-1:0] pinIn,
  output logic      [WIDTH-1:0] pinOut
);

  logic [WIDTH-1:0] stage1_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      stage1_q <= '0;
      pinOut   <= '0;
    end else if (clkEnable) begin
      stage1_q <= pinIn;
      pinOut   <= stage1_q;
    end
  end

endmodule

`default_nettype wire

/* verification/fofc_props.sv */
// Port checker of the flag offset control block.
// Assumes a bind to the block; ref_clk and rst are its clock and reset.
`timescale 1ns/1ns
`default_nettype none
module fofc_props (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic masterReset_n,
  input wire logic memWriteStrobe,
  input wire logic memReadStrobe,
  input wire logic emptyFlag,
  input wire logic fullFlag,
  input wire logic halfFullFlag,
  input wire logic almostEmptyFlag,
  input wire logic almostFullFlag,
  input wire logic offsetsValid,
  input wire logic firstWordFallThrough,
  input wire logic serialLoadMode
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  a_reset_flag_state: assert property (disable iff (1'b0) rst |=> !emptyFlag && fullFlag
    && halfFullFlag && !almostEmptyFlag && almostFullFlag) else $error("flags off after reset");
  a_write_not_full: assert property (memWriteStrobe |-> $past(fullFlag) != firstWordFallThrough)
    else $error("write taken when full");
  a_read_not_empty: assert property (memReadStrobe |-> $past(emptyFlag) != firstWordFallThrough)
    else $error("read taken when empty");
  a_write_pulse: assert property (memWriteStrobe |=> !memWriteStrobe) else $error("long write strobe");
  a_read_pulse: assert property (memReadStrobe |=> !memReadStrobe) else $error("long read strobe");
  a_mode_held: assert property (masterReset_n [*6] |-> $stable(serialLoadMode)
    && $stable(firstWordFallThrough)) else $error("mode moved outside master reset");
  a_flags_frozen: assert property (!offsetsValid && !$past(offsetsValid) |->
    $stable(almostEmptyFlag) && $stable(almostFullFlag)) else $error("flag moved while invalid");
  a_empty_is_almost: assert property (offsetsValid && !firstWordFallThrough && !emptyFlag
    |-> !almostEmptyFlag) else $error("almost empty high while empty");
  c_mem_write: cover property (memWriteStrobe);
  c_serial_load: cover property ($rose(offsetsValid));
  c_fall_through: cover property (firstWordFallThrough && memReadStrobe);
endmodule
bind fofc_flag_offset_ctrl fofc_props i_fofc_props (.*);
`default_nettype wire

/* verification/fofc_mem_model.sv */
// Memory array model behind the block's memory strobes.
// Assumes one word per strobe; an empty head shows the last word inverted.
`timescale 1ns/1ns
`default_nettype none
module fofc_mem_model (
  input  wire logic        ref_clk,
  input  wire logic        masterReset_n,
  input  wire logic        memWriteStrobe,
  input  wire logic [35:0] memWriteData,
  input  wire logic        memReadStrobe,
  output logic      [35:0] memReadData
);
  logic [35:0] store[$];
  logic [35:0] last = '0;
  always @(posedge ref_clk) begin
    if (!masterReset_n) store.delete();
    if (memWriteStrobe) store.push_back(memWriteData);
    if (memReadStrobe && store.size() > 0) last = store.pop_front();
    memReadData <= (store.size() > 0) ? store[0] : ~last;
  end
endmodule
`default_nettype wire

/* verification/fofc_flag_offset_ctrl_test.sv */
// Bench of the flag offset control block: pin traffic checked against a queue model.
// Assumes the memory model on the memory strobes and the bound checker.
`timescale 1ns/1ns
`default_nettype none
module fofc_flag_offset_ctrl_test
  import fofc_pkg::*;
;
  logic ref_clk = 0, rst = 1, clkEnable = 1, writeClkPin = 0, readClkPin = 0, masterReset_n = 0;
  logic writeEnablePin_n = 1, readEnablePin_n = 1, offsetLoadSelect = 1, serialShiftEnable = 1;
  logic defaultOffsetPick0 = 0, defaultOffsetPick1 = 0, flagTimingSelect = 0, timingSelectSerialIn = 0;
  logic memWriteStrobe, memReadStrobe, emptyFlag, fullFlag, halfFullFlag, almostEmptyFlag;
  logic almostFullFlag, offsetsValid, firstWordFallThrough, serialLoadMode, ft, sy, aeE, afE;
  logic [35:0] dataInputBus = '0, memReadData, dataOutputBus, memWriteData;
  logic [35:0] q[$];
  int error_cnt = 0, check_count = 0, n, m, cnt, top, stb = 0;
  int defs[8] = '{127, 8191, 16383, 4095, 1023, 511, 2047, 255};
  fofc_flag_offset_ctrl i_fofc_flag_offset_ctrl (.*);
  fofc_mem_model i_fofc_mem_model (.*);
  initial forever #10 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (memWriteStrobe === 1'b1 || memReadStrobe === 1'b1) stb++;
  initial begin
    repeat (4000) @(posedge ref_clk);
    error_cnt++;
    summarize();
  end
  task chk(input string s, input logic [35:0] seen, input logic [35:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s exp %h seen %h", s, exp, seen);
    end
  endtask
  task summarize();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Controls settle three cycles before the pin clock edge and hold past it.
  task op(input logic w, l, we, re, se, si, input logic [35:0] d);
    offsetLoadSelect <= l;
    writeEnablePin_n <= we;
    readEnablePin_n <= re;
    serialShiftEnable <= se;
    timingSelectSerialIn <= si;
    dataInputBus <= d;
    repeat (3) @(posedge ref_clk);
    if (w) writeClkPin <= 1'b1;
    else readClkPin <= 1'b1;
    repeat (3) @(posedge ref_clk);
    writeClkPin <= 1'b0;
    readClkPin <= 1'b0;
    repeat (4) @(posedge ref_clk);
  endtask
  task mres(input logic [2:0] k, input logic f, input logic s);
    {offsetLoadSelect, defaultOffsetPick1, defaultOffsetPick0} <= k;
    timingSelectSerialIn <= f;
    flagTimingSelect <= s;
    masterReset_n <= 1'b0;
    repeat (5) @(posedge ref_clk);
    masterReset_n <= 1'b1;
    repeat (5) @(posedge ref_clk);
    ft = f;
    sy = s;
    top = 65536 + f;
    cnt = 0;
    n = defs[k];
    m = n;
    aeE = 0;
    afE = 1;
    q.delete();
  endtask
  task flags();
    chk("emptyFlag", emptyFlag, ft ? cnt == 0 : cnt != 0);
    chk("fullFlag", fullFlag, ft ? cnt == top : cnt != top);
    chk("halfFullFlag", halfFullFlag, cnt <= 32768 + ft);
    chk("almostEmptyFlag", almostEmptyFlag, aeE);
    chk("almostFullFlag", almostFullFlag, afE);
  endtask
  task mem(input logic w);
    logic [35:0] d;
    logic ok, aeC, afC;
    int s0;
    d[31:0] = $urandom();
    d[35:32] = 4'($urandom());
    s0 = stb;
    ok = w ? cnt < top : cnt > 0;
    op(w, 1'b1, !w, w, 1'b1, 1'b0, d);
    chk("strobes", stb - s0, ok);
    if (ok && w) begin
      cnt++;
      q.push_back(d);
      chk("memWriteData", memWriteData, d);
    end
    if (ok && !w) begin
      cnt--;
      chk("dataOutputBus", dataOutputBus, q.pop_front());
    end
    aeC = cnt > n + ft;
    afC = cnt < top - m;
    if (w) begin
      afE = sy ? afC : afE & afC;
      aeE = sy ? aeE : aeE | aeC;
    end else begin
      aeE = sy ? aeC : aeE & aeC;
      afE = sy ? afE : afE | afC;
    end
    flags();
  endtask
  task ofsWr(input logic [31:0] v);
    for (int i = 0; i < 4; i++) op(1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, {28'h0, v[8*i+:8]});
  endtask
  task ofsRd(input logic [31:0] v);
    for (int i = 0; i < 4; i++) begin
      op(1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, '0);
      chk("offset byte", dataOutputBus, {28'h0, v[8*i+:8]});
    end
  endtask
  initial begin
    logic [31:0] v;
    int s;
    void'($urandom(32'hc1da_d9ba));
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    for (int k = 0; k < 8; k++) begin
      mres(3'(k), 1'($urandom()), 1'($urandom()));
      chk("serialLoadMode", serialLoadMode, k[2]);
      chk("firstWordFallThrough", firstWordFallThrough, ft);
      flags();
      ofsRd({2{16'(defs[k])}});
    end
    for (int f = 0; f < 2; f++) begin
      mres(3'b000, 1'(f), 1'(f));
      n = 2;
      m = 65533;
      v = {16'hfffd, 16'h0002};
      ofsWr(v);
      ofsRd(v);
      mem(1'b0);
      repeat (5) mem(1'b1);
      s = stb;
      op(1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, '0);
      chk("idle strobes", stb - s, 0);
      // A memory write made while the clock enable is low must leave no trace.
      clkEnable <= 1'b0;
      op(1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 36'($urandom()));
      clkEnable <= 1'b1;
      chk("frozen strobes", stb - s, 0);
      chk("memWriteData", memWriteData, q[$]);
      repeat (6) mem(1'b0);
      // Leave both offset pointers off zero so that the next master reset must move them back.
      op(1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 36'h0_0000_0002);
      op(1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, '0);
      chk("offset byte", dataOutputBus, 36'h0_0000_0002);
    end
    mres(3'b100, 1'b0, 1'b1);
    v = $urandom();
    ofsWr(v);
    ofsRd({2{16'h03ff}});
    for (int i = 0; i < 32; i++) begin
      op(1'b1, 1'b0, 1'b1, 1'b1, 1'b0, v[i], '0);
      if (i == 0) chk("offsetsValid", offsetsValid, 1'b0);
    end
    chk("offsetsValid", offsetsValid, 1'b1);
    ofsRd(v);
    summarize();
  end
endmodule
`default_nettype wire
